// [ssp_regs.vh]
// Register map, field positions, reset values and timing counts of the SPI port.
// Assumes an 8-bit special-function register space addressed by byte.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// ==========================================================
// Register offsets
`define SSP_ADDR_OUTCFG   8'h8F
`define SSP_ADDR_CTRL     8'h9D
`define SSP_ADDR_STAT     8'h9E
`define SSP_ADDR_DATA     8'h9F
`define SSP_ADDR_IRQ_ST   8'hA0
`define SSP_ADDR_IRQ_MSK  8'hA1
// ==========================================================
// Field positions
`define SSP_SEL_HI        7
`define SSP_SEL_LO        6
`define SSP_SEL_SPI       2'h1
`define SSP_CTRL_ON       7
`define SSP_CTRL_ROLE     5
`define SSP_CTRL_IDLE     4
`define SSP_CTRL_EDGE     3
`define SSP_CTRL_DIV_HI   2
`define SSP_STAT_DONE     7
`define SSP_STAT_WRITE_COLLISION_FLAG     6
`define SSP_STAT_TXE      3
`define SSP_STAT_ORDER    2
`define SSP_STAT_TRANSMIT_EMPTY_IRQ_ENABLE     0
// ==========================================================
// Reset values
`define SSP_RST_OUTCFG    8'h00
`define SSP_RST_CTRL      8'h00
`define SSP_RST_STAT      8'h08
`define SSP_RST_DATA      8'h00
// Writable bits
`define SSP_MASK_OUTCFG   8'hCF
`define SSP_MASK_CTRL     8'hBF
// ==========================================================
// Timing: shortest divisor is 4, so half period is 2 system clocks
`define SSP_DIV_BASE_HALF 10'h002
`define SSP_BITS          4'h8
// Master reads MISO this many clocks after its own capture edge (pin sync lag)
`define SSP_MISO_LAG      3'h4
`endif

// [ssp_sync.v]
// Three-stage synchroniser bank for pins entering the system clock domain.
// Assumes inputs are asynchronous levels; outputs the agreed value.
`timescale 1ns/1ps
module ssp_sync #(
  parameter W = 3
) (
  input  wire         i_clk_sys,  // System clock
  input  wire         i_arst_n,   // Async reset
  input  wire [W-1:0] i_async,    // Raw pin levels
  output wire [W-1:0] o_level     // Filtered levels
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] lvl_r;
  // ==========================================================
  // Stage chain: value moves once stages two and three agree
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r  <= {W{1'b0}};
      s2_r  <= {W{1'b0}};
      s3_r  <= {W{1'b0}};
      lvl_r <= {W{1'b0}};
    end else begin
      s1_r  <= i_async;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
    end
  end
  assign o_level = lvl_r;
endmodule // ssp_sync

// [ssp_core.v]
// SPI function of the shared serial block: registers, master clock, shifter.
// Assumes a single-cycle SFR port and external pins resolved by the bench.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "ssp_regs.vh"
// Contract
// - Block select 01 and control bit 7 set mean SPI active
// - Full duplex shift out and in
// - Control 9D, status 9E, data 9F
// - Control bit 5 picks master role
// - Control bit 4 sets clock idle
// - Control bit 3 picks sampling edge
// - Divider code gives fsys/4 to /512
// - Done flag set, software writes zero
// - Collision flag set, software writes zero
// - Status bit 2 selects LSB first
// - Empty flag with enable raises interrupt
// - Data write loads shifter, read receives
// - Master starts on write, collisions flagged
// - Unselected slave floats MISO, ignores clock
// - Unloaded slave sends zero byte
// - Slave holds byte while done flag set
module ssp_core (
  input  wire       i_clk_sys,   // System clock 20 MHz
  input  wire       i_arst_n,    // Async reset, active low
  input  wire [7:0] i_addr,      // SFR address
  input  wire [7:0] i_wdata,     // Write data
  input  wire       i_wr,        // Write strobe
  input  wire       i_rd,        // Read strobe
  output reg  [7:0] o_rdata,     // Read data, cycle after strobe
  output wire       o_irq,       // Level interrupt
  input  wire       i_sck,       // Serial clock in (slave)
  output reg        o_sck,       // Serial clock out (master)
  output wire       o_sck_oe,    // Serial clock drive enable
  input  wire       i_mosi,      // MOSI in (slave)
  output reg        o_mosi,      // MOSI out (master)
  output wire       o_mosi_oe,   // MOSI drive enable
  input  wire       i_miso,      // MISO in (master)
  output wire       o_miso,      // MISO out (slave)
  output wire       o_miso_oe,   // MISO drive enable
  input  wire       i_sel_n      // Slave select, active low
);
  // ==========================================================
  // Declarations
  reg  [7:0] outcfg_r;
  reg  [7:0] ctrl_r;
  reg  [7:0] stat_r;
  reg  [7:0] rx_r;
  reg  [7:0] tx_r;
  reg  [7:0] sh_r;
  reg  [2:0] irq_st_r;
  reg  [2:0] irq_msk_r;
  reg        busy_r;
  reg        loaded_r;
  reg  [3:0] edges_r;
  reg  [9:0] div_r;
  reg        sck_d_r;
  reg        miso_bit_r;
  reg        in_bit_r;
  reg  [3:0] cap_d_r;
  reg  [2:0] tail_r;
  reg  [7:0] mrx_r;
  wire [3:0] pins;
  wire       sck_s;
  wire       mosi_s;
  wire       miso_s;
  wire       spi_on;
  wire       master;
  wire       idle_level;
  wire       sample_edge;
  wire       lsb;
  wire       slave_sel;
  wire       sck_edge;
  wire       lead_edge;
  wire       trail_edge;
  wire       wr_data;
  wire       collide;
  wire       done_evt;
  wire       m_cap;
  wire       m_done;
  wire       fin_evt;
  wire       rd_istat;
  wire [9:0] half_cnt;
  wire [7:0] tx_next;
  // ==========================================================
  // Helpers
  function [9:0] half_period;
    input [2:0] code;
    begin
      half_period = `SSP_DIV_BASE_HALF << code;
    end
  endfunction
  function out_bit;
    input [7:0] v;
    input       lsb_first;
    begin
      out_bit = lsb_first ? v[0] : v[7];
    end
  endfunction
  function [7:0] shift_in;
    input [7:0] v;
    input       b;
    input       lsb_first;
    begin
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
    end
  endfunction
  // ==========================================================
  // Pin synchronisers
  // Select enters inverted, so the reset value of the chain means deselected
  ssp_sync #(.W(4)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_async   ({i_sck, i_mosi, i_miso, ~i_sel_n}),
    .o_level   (pins)
  );
  assign sck_s  = pins[3];
  assign mosi_s = pins[2];
  assign miso_s = pins[1];
  // ==========================================================
  // Mode decode
  // SPI only with select 01
  assign spi_on = (outcfg_r[`SSP_SEL_HI:`SSP_SEL_LO] == `SSP_SEL_SPI) & ctrl_r[`SSP_CTRL_ON];
  assign master = ctrl_r[`SSP_CTRL_ROLE];
  assign idle_level   = ctrl_r[`SSP_CTRL_IDLE];
  assign sample_edge   = ctrl_r[`SSP_CTRL_EDGE];
  // status bit 2 picks bit order
  assign lsb    = stat_r[`SSP_STAT_ORDER];
  assign slave_sel = spi_on & ~master & pins[0];  // Synchronised select
  assign half_cnt = half_period(ctrl_r[`SSP_CTRL_DIV_HI:0]);
  assign wr_data  = i_wr & (i_addr == `SSP_ADDR_DATA);
  assign rd_istat = i_rd & (i_addr == `SSP_ADDR_IRQ_ST);
  // write while a byte is pending collides
  assign collide  = wr_data & spi_on & (busy_r | (loaded_r & ~master));
  // slave with nothing loaded sends zero
  assign tx_next  = loaded_r ? tx_r : 8'h00;
  // ==========================================================
  // Clock edge source: master divider or synchronised pin
  assign sck_edge   = master ? (busy_r & (tail_r == 3'h0) & (div_r == 10'h001))
                             : (slave_sel & (sck_s != sck_d_r));
  // odd edge is first edge of a bit cycle
  assign lead_edge  = sck_edge & ~edges_r[0];
  assign trail_edge = sck_edge & edges_r[0];
  assign done_evt   = sck_edge & (edges_r == 4'hF);
  // master samples MISO late, since the pin sync costs four clocks
  assign m_cap      = master & ((lead_edge & ~sample_edge) | (trail_edge & sample_edge));
  assign m_done     = busy_r & (tail_r == 3'h1);
  assign fin_evt    = master ? m_done : (done_evt & busy_r);
  // ==========================================================
  // Shift engine
  // full duplex shifter
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_r       <= 8'h00;
      rx_r       <= 8'h00;
      busy_r     <= 1'b0;
      loaded_r   <= 1'b0;
      tx_r       <= `SSP_RST_DATA;
      edges_r    <= 4'h0;
      div_r      <= 10'h000;
      o_sck      <= 1'b0;
      o_mosi     <= 1'b0;
      miso_bit_r <= 1'b0;
      in_bit_r   <= 1'b0;
      sck_d_r    <= 1'b0;
      cap_d_r    <= 4'h0;
      tail_r     <= 3'h0;
      mrx_r      <= 8'h00;
    end else begin
      sck_d_r <= sck_s;
      cap_d_r <= {cap_d_r[2:0], m_cap};
      if (!spi_on) begin
        busy_r  <= 1'b0;
        tail_r  <= 3'h0;
        edges_r <= 4'h0;
        o_sck   <= idle_level;
        if (wr_data) begin
          tx_r     <= i_wdata;
          loaded_r <= 1'b1;
        end
      end else if (wr_data && !collide) begin
        tx_r     <= i_wdata;
        loaded_r <= 1'b1;
        if (master) begin
          busy_r  <= 1'b1;
          sh_r    <= i_wdata;
          o_mosi  <= out_bit(i_wdata, lsb);
          edges_r <= 4'h0;
          div_r   <= half_cnt;
        end
      end else begin
        // master clock rests at the idle level between bytes
        if (!busy_r) begin
          o_sck <= idle_level;
        end
        tail_r <= (tail_r == 3'h0) ? 3'h0 : tail_r - 3'h1;
        if (cap_d_r[3]) begin  // Late MISO sample, after the sync lag
          mrx_r <= shift_in(mrx_r, miso_s, lsb);
        end
        if (!master && !busy_r && slave_sel && !stat_r[`SSP_STAT_DONE]) begin
          // slave idle until done flag cleared
          busy_r     <= 1'b1;
          sh_r       <= tx_next;
          miso_bit_r <= out_bit(tx_next, lsb);
          edges_r    <= 4'h0;
          loaded_r   <= 1'b0;
        end
        if (!master && !slave_sel && busy_r) begin
          busy_r  <= 1'b0;
          edges_r <= 4'h0;
        end
        if (master && busy_r) begin
          div_r <= (div_r == 10'h001) ? half_cnt : div_r - 10'h001;
        end
        if (sck_edge && busy_r) begin
          edges_r <= edges_r + 4'h1;
          if (master) begin
            o_sck <= ~o_sck;
          end
          if ((lead_edge && !sample_edge) || (trail_edge && sample_edge)) begin
            in_bit_r <= master ? miso_s : mosi_s;
            sh_r     <= shift_in(sh_r, master ? miso_s : mosi_s, lsb);
          end else if (edges_r != 4'h0 || sample_edge) begin
            if (master) begin
              o_mosi <= out_bit(sh_r, lsb);
            end else begin
              miso_bit_r <= out_bit(sh_r, lsb);
            end
          end
          if (done_evt && master) begin
            tail_r <= `SSP_MISO_LAG;
          end else if (done_evt) begin
            busy_r   <= 1'b0;
            rx_r     <= sample_edge ? shift_in(sh_r, mosi_s, lsb) : sh_r;
            loaded_r <= 1'b0;
          end
        end
        // Master byte is complete once the last late sample is in
        if (m_done) begin
          busy_r   <= 1'b0;
          rx_r     <= cap_d_r[3] ? shift_in(mrx_r, miso_s, lsb) : mrx_r;
          loaded_r <= 1'b0;
        end
      end
    end
  end
  // ==========================================================
  // Pin drivers: slave MISO floats unless selected
  assign o_sck_oe  = spi_on & master;
  assign o_mosi_oe = spi_on & master;
  assign o_miso    = miso_bit_r;
  assign o_miso_oe = slave_sel;
  // ==========================================================
  // Registers: software writes and hardware flags
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      outcfg_r <= `SSP_RST_OUTCFG;
      ctrl_r   <= `SSP_RST_CTRL;
      stat_r   <= `SSP_RST_STAT;
    end else begin
      if (i_wr && i_addr == `SSP_ADDR_OUTCFG) begin
        outcfg_r <= i_wdata & `SSP_MASK_OUTCFG;
      end
      if (i_wr && i_addr == `SSP_ADDR_CTRL) begin
        ctrl_r <= i_wdata & `SSP_MASK_CTRL;
      end
      if (i_wr && i_addr == `SSP_ADDR_STAT) begin
        // Flags only clear by writing 0; writing 1 keeps them
        stat_r[`SSP_STAT_DONE]  <= stat_r[`SSP_STAT_DONE] & i_wdata[`SSP_STAT_DONE];
        stat_r[`SSP_STAT_WRITE_COLLISION_FLAG]  <= stat_r[`SSP_STAT_WRITE_COLLISION_FLAG] & i_wdata[`SSP_STAT_WRITE_COLLISION_FLAG];
        stat_r[`SSP_STAT_ORDER] <= i_wdata[`SSP_STAT_ORDER];
        stat_r[`SSP_STAT_TRANSMIT_EMPTY_IRQ_ENABLE]  <= i_wdata[`SSP_STAT_TRANSMIT_EMPTY_IRQ_ENABLE];
      end
      if (fin_evt) begin
        stat_r[`SSP_STAT_DONE] <= 1'b1;
      end
      if (collide) begin
        stat_r[`SSP_STAT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (wr_data && !collide) begin
        stat_r[`SSP_STAT_TXE] <= 1'b0;
      end else if (fin_evt) begin
        stat_r[`SSP_STAT_TXE] <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Sticky interrupt status: done, collision, empty; read clears
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_st_r  <= 3'h0;
      irq_msk_r <= 3'h0;
    end else begin
      if (i_wr && i_addr == `SSP_ADDR_IRQ_MSK) begin
        irq_msk_r <= i_wdata[2:0];
      end
      // New events win over the clearing read
      irq_st_r <= (rd_istat ? 3'h0 : irq_st_r)
                | {fin_evt, collide, fin_evt & ~stat_r[`SSP_STAT_TXE]};
    end
  end
  // empty flag and enable raise interrupt
  assign o_irq = (stat_r[`SSP_STAT_TXE] & stat_r[`SSP_STAT_TRANSMIT_EMPTY_IRQ_ENABLE])
               | (|(irq_st_r & irq_msk_r));
  // ==========================================================
  // Read port, data one cycle after the strobe
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `SSP_ADDR_OUTCFG:  o_rdata <= outcfg_r;
        `SSP_ADDR_CTRL:    o_rdata <= ctrl_r;
        `SSP_ADDR_STAT:    o_rdata <= stat_r & 8'hCD;
        `SSP_ADDR_DATA:    o_rdata <= rx_r;
        `SSP_ADDR_IRQ_ST:  o_rdata <= {5'h00, irq_st_r};
        `SSP_ADDR_IRQ_MSK: o_rdata <= {5'h00, irq_msk_r};
        default:           o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // ssp_core

// [ssp_core_sva_pkgless.svh]
// Shared limits for the SPI port checks and bench.
// Assumes inclusion after ssp_regs.vh where both are used.
`ifndef SSP_CORE_SVA_PKGLESS_SVH
`define SSP_CORE_SVA_PKGLESS_SVH
// ==========================================================
// Poll limit for a finished transfer, in status reads
`define SSP_TB_POLL 9000
`endif

// [ssp_core_sva.sv]
// Checker: port-level timing of the SPI port.
// Assumes it is bound to ssp_core and sees only its ports.
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_core_sva (
  input wire       i_clk_sys, // System clock
  input wire       i_arst_n,  // Async reset
  input wire [7:0] i_addr,    // SFR address
  input wire [7:0] i_wdata,   // Write data
  input wire       i_wr,      // Write strobe
  input wire       i_rd,      // Read strobe
  input wire [7:0] o_rdata,   // Read data
  input wire       o_sck,     // Clock out
  input wire       o_sck_oe,  // Clock enable
  input wire       o_mosi_oe, // MOSI enable
  input wire       o_miso_oe, // MISO enable
  input wire       i_sel_n    // Select, active low
);
  // ==========================================================
  // Shadow of mode bits, so pin enables can be predicted
  reg [7:0] cfg_r;
  reg [7:0] ctl_r;
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= 8'h00;
      ctl_r <= 8'h00;
    end else if (i_wr && i_addr == `SSP_ADDR_OUTCFG) begin
      cfg_r <= i_wdata;
    end else if (i_wr && i_addr == `SSP_ADDR_CTRL) begin
      ctl_r <= i_wdata;
    end
  end
  wire spi_on = (cfg_r[7:6] == `SSP_SEL_SPI) && ctl_r[7];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  // ==========================================================
  // Properties
  chk_oe_master: assert property (o_sck_oe == (spi_on && ctl_r[5]))
    else $error("clock enable disagrees with role");
  chk_oe_pair: assert property (o_mosi_oe == o_sck_oe)
    else $error("MOSI enable differs from clock enable");
  chk_miso_role: assert property (o_miso_oe |-> spi_on && !ctl_r[5])
    else $error("MISO driven outside slave role");
  chk_miso_float: assert property (i_sel_n [*5] |-> !o_miso_oe)
    else $error("MISO driven while not selected");
  chk_rd_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_ctrl_read: assert property (s_rd(`SSP_ADDR_CTRL) |=> o_rdata == (ctl_r & 8'hBF))
    else $error("control read back wrong");
  chk_stat_rsvd: assert property (s_rd(`SSP_ADDR_STAT) |=> o_rdata[5:4] == 2'h0 && !o_rdata[1])
    else $error("reserved status bits set");
  // Shortest divisor is 4, so no half period under 2 clocks
  chk_sck_hold: assert property (o_sck_oe && $changed(o_sck) |=> $stable(o_sck))
    else $error("serial clock half period too short");
endmodule // ssp_core_sva

bind ssp_core ssp_core_sva u_chk (.*);

// [ssp_slave_model.sv]
// Far-side SPI slave used while the port is master.
// Assumes the bench sets the mode before selecting it.
`timescale 1ns/1ps
module ssp_slave_model (
  input  wire       i_sck,   // Serial clock
  input  wire       i_mosi,  // Data from master
  input  wire       i_sel_n, // Select, active low
  input  wire       i_idle_level,  // Idle level
  input  wire       i_sample_edge,  // Sample edge
  input  wire       i_lsb,   // Bit order
  input  wire [7:0] i_tx,    // Byte to send
  output reg        o_miso,  // Data to master
  output reg  [7:0] o_rx     // Byte received
);
  reg [7:0] sh_r;
  reg       wait_r;
  initial o_miso = 1'b0;
  // Load on select, before any clock edge
  always @(negedge i_sel_n) begin
    sh_r = i_tx;
    wait_r = i_sample_edge;
    o_miso = i_lsb ? i_tx[0] : i_tx[7];
  end
  // Capture on sampling edge, shift on the other
  always @(i_sck) begin
    if (!i_sel_n) begin
      if ((i_sck != i_idle_level) ^ i_sample_edge) begin
        o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end else begin
        if (!wait_r) sh_r = i_lsb ? sh_r >> 1 : sh_r << 1;
        wait_r = 1'b0;
        o_miso = i_lsb ? sh_r[0] : sh_r[7];
      end
    end
  end
  // Released line flips, so a stale bit is never read as valid
  always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule // ssp_slave_model

// [testbench.sv]
// Bench: drives the SFR port and both SPI roles, checks against integers.
// Assumes ssp_core with pins resolved here and a slave model beyond it.
`timescale 1ns/1ps
`include "ssp_regs.vh"
`include "ssp_core_sva_pkgless.svh"
module testbench;
  reg        clk = 0, rst_n = 0, wr = 0, rd = 0, sck = 0, mosi = 0;
  reg        sel_n = 1, m_sel_n = 1, idle_level = 0, sample_edge = 0, lsb = 0, ps = 0;
  reg  [7:0] addr = 0, wd = 0, q = 0, so = 0, b, d, m_tx = 0;
  wire [7:0] rdata, m_rx;
  wire       irq, osck, sck_oe, omosi, mosi_oe, omiso, miso_oe, m_miso;
  wire       sck_w = sck_oe ? osck : sck;
  wire       mosi_w = mosi_oe ? omosi : mosi;
  wire       miso_w = miso_oe ? omiso : m_miso;
  integer    error_cnt = 0, compares = 0, k, n, x, hp = 0, gap = 0;
  initial forever #25 clk = ~clk;
  ssp_core DUT (.i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_sck(sck_w), .o_sck(osck),
    .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(omosi), .o_mosi_oe(mosi_oe),
    .i_miso(miso_w), .o_miso(omiso), .o_miso_oe(miso_oe), .i_sel_n(sel_n));
  ssp_slave_model u_far (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(m_sel_n),
    .i_idle_level(idle_level), .i_sample_edge(sample_edge), .i_lsb(lsb), .i_tx(m_tx), .o_miso(m_miso), .o_rx(m_rx));
  // Clocks between serial clock toggles
  always @(posedge clk) begin
    ps <= osck;
    gap <= (osck != ps) ? 1 : gap + 1;
    if (osck != ps && sck_oe) hp <= gap;
  end
  task chk(input string nm, input [15:0] e, s);
    compares = compares + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrr(input [7:0] a, v);
    @(posedge clk) begin addr <= a; wd <= v; wr <= 1; end
    @(posedge clk) wr <= 0;
    @(negedge clk);
  endtask
  task rdr(input [7:0] a);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    @(negedge clk) q = rdata;
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Poll the done flag, bounded
  task wdone;
    n = 0;
    q = 0;
    while (q[7] !== 1'b1 && n < `SSP_TB_POLL) begin rdr(`SSP_ADDR_STAT); n = n + 1; end
    if (n >= `SSP_TB_POLL) begin error_cnt = error_cnt + 1; stop_test; end
  endtask
  // Bench as master, mode 0; MISO read late to allow for pin sync delay
  task xfer(input [7:0] v);
    @(posedge clk) sel_n <= 0;
    repeat (8) @(posedge clk);
    for (x = 7; x >= 0; x = x - 1) begin
      mosi <= v[x];
      repeat (4) @(posedge clk) sck <= 1;
      repeat (4) @(posedge clk) sck <= 0;
      so[x] = miso_w;
    end
    repeat (8) @(posedge clk);
    sel_n <= 1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    x = $urandom(59);
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rdr(`SSP_ADDR_OUTCFG); chk("outcfg", 8'h00, q);
    rdr(`SSP_ADDR_CTRL); chk("ctrl", 8'h00, q);
    rdr(`SSP_ADDR_STAT); chk("status", 8'h08, q);
    rdr(`SSP_ADDR_DATA); chk("data", 8'h00, q);
    rdr(8'h00); chk("unmapped", 8'h00, q);
    wrr(`SSP_ADDR_CTRL, 8'hFF); wrr(`SSP_ADDR_OUTCFG, 8'hFF); wrr(`SSP_ADDR_IRQ_MSK, 8'h00);
    rdr(`SSP_ADDR_CTRL); chk("ctrl rw", 8'hBF, q);
    chk("sck_oe uart", 0, sck_oe);
    wrr(`SSP_ADDR_OUTCFG, 8'h40); chk("sck_oe spi", 1, sck_oe);
    wrr(`SSP_ADDR_STAT, 8'h01); chk("irq on", 1, irq);
    wrr(`SSP_ADDR_STAT, 8'h00); chk("irq off", 0, irq);
    $display("test registers done");
    for (k = 0; k < 8; k = k + 1) begin
      {lsb, sample_edge, idle_level} = k[2:0];
      m_tx = $urandom;
      b = $urandom;
      wrr(`SSP_ADDR_CTRL, {3'h5, idle_level, sample_edge, k[2:0]});
      wrr(`SSP_ADDR_STAT, {5'h0, lsb, 2'h0});
      m_sel_n <= 0;
      wrr(`SSP_ADDR_DATA, b);
      if (k == 0) wrr(`SSP_ADDR_DATA, ~b);
      wdone;
      chk("write_collision_flag", k == 0, q[6]);
      chk("half period", 2 << k, hp);
      chk("idle", idle_level, osck);
      rdr(`SSP_ADDR_DATA); chk("master rx", m_tx, q);
      chk("far rx", b, m_rx);
      wrr(`SSP_ADDR_IRQ_MSK, 8'h04); chk("irq sticky", 1, irq);
      wrr(`SSP_ADDR_IRQ_MSK, 8'h00);
      rdr(`SSP_ADDR_IRQ_ST); chk("sticky", k == 0 ? 7 : 5, q);
      rdr(`SSP_ADDR_IRQ_ST); chk("sticky clr", 0, q);
      wrr(`SSP_ADDR_STAT, {5'h0, lsb, 2'h0});
      rdr(`SSP_ADDR_STAT); chk("flags clr", 0, q[7:6]);
      m_sel_n <= 1;
    end
    $display("test master done");
    wrr(`SSP_ADDR_CTRL, 8'h80); wrr(`SSP_ADDR_STAT, 8'h00);
    chk("miso float", 0, miso_oe);
    b = $urandom;
    xfer(b); chk("zero byte", 0, so);
    rdr(`SSP_ADDR_DATA); chk("slave rx", b, q);
    xfer(~b); rdr(`SSP_ADDR_DATA); chk("held", b, q);
    d = $urandom;
    wrr(`SSP_ADDR_STAT, 8'h00); wrr(`SSP_ADDR_DATA, d);
    xfer(b); chk("slave tx", d, so);
    $display("test slave done");
    stop_test;
  end
endmodule // testbench
